// ### src/srcap_ctrl.sv
// SYSREF capture control: APB registers, capture modes, skew check and timestamp.
//
// Notes on behaviour
// RL1: While flag reset is one, setup and hold error flags stay cleared.
// RL2: Transition select zero accepts rising SYSREF, one accepts falling SYSREF.
// RL3: Software disables capture mode before changing the transition polarity.
// RL4: Edge select zero samples on rising clock edge, one on falling.
// RL5: Mode 0 disabled, 1 continuous, 2 N-shot capture.
// RL6: N-shot skips the ignore count of valid transitions, then acts.
// RL7: Negative window, 0 to 3 clocks early, tolerated without flagging.
// RL8: Positive window, 0 to 3 clocks late, tolerated without flagging.
// RL9: A window of zero tolerates no skew in that direction.
// RL10: Timestamp delayed by 0 to 127 sample clocks, reset zero.
// RL11: Eight-bit capture counter increments, wraps, cleared by flag reset.
// RL12: Software reads the capture count only while capture is disabled.
// RL13: After an N-shot acts, ignore transitions until disabled and re-armed.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module srcap_ctrl
  import srcap_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_LEN_DEF,
  parameter int DLY_DEPTH = DLY_DEPTH_DEF
)
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference input.
  input wire logic sysref_in,
  // Capture results.
  output logic capture_pulse,
  output logic stamp_pulse,
  output logic [$clog2(FRAME_LEN)-1:0] frame_phase,
  // Interrupt.
  output logic irq
);

  localparam int PH_W = $clog2(FRAME_LEN);
  localparam int TAP_W = $clog2(DLY_DEPTH);

  if (FRAME_LEN < 8 || (FRAME_LEN & (FRAME_LEN - 1)) != 0) begin : g_chk_frame
    $error("FRAME_LEN must be a power of two of at least 8");
  end
  if (DLY_DEPTH < 128) begin : g_chk_dly
    $error("DLY_DEPTH must cover delays up to 127");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  srcap_cfg_t cfg_r;
  srcap_skew_t skew_r;
  logic [3:0] ign_r;
  logic [6:0] tsd_r;
  logic setup_flag_r;
  logic hold_flag_r;
  logic [7:0] count_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;
  srcap_nshot_t ns_r;
  srcap_nshot_t ns_nxt;
  logic [3:0] skip_r;
  logic [PH_W-1:0] ph_r;
  logic capt_r;
  logic valid_pulse;
  logic capture;
  logic setup_err;
  logic hold_err;
  logic misaligned;
  logic [PH_W:0] late_dist;
  logic [PH_W:0] early_dist;
  logic wr_en;
  logic [31:0] rd_data;
  logic hit;
  logic [IRQ_W-1:0] irq_evt;

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // Zero wait states.
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & hit;
  assign pslverr = psel & penable & ~hit;

  // Read decode; reserved bits read as zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      ADDR_CFG: begin
        rd_data[CFG_FLAG_RST_BIT] = cfg_r.flag_rst;
        rd_data[CFG_TRANS_BIT] = cfg_r.trans_sel;
        rd_data[CFG_EDGE_BIT] = cfg_r.edge_sel;
        rd_data[CFG_MODE_LSB +: 2] = cfg_r.mode;
      end
      ADDR_IGN: rd_data[IGN_LSB +: 4] = ign_r;
      ADDR_SKEW: begin
        rd_data[SKEW_NEG_LSB +: 2] = skew_r.neg;
        rd_data[SKEW_POS_LSB +: 2] = skew_r.pos;
      end
      ADDR_TSD: rd_data[TSD_LSB +: 7] = tsd_r;
      ADDR_FLAGS: begin
        rd_data[FLAG_SETUP_BIT] = setup_flag_r;
        rd_data[FLAG_HOLD_BIT] = hold_flag_r;
      end
      ADDR_COUNT: rd_data[7:0] = count_r;
      ADDR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_r;
      default: hit = 1'b0;
    endcase
  end

  // Read data is taken in the setup cycle, so prdata is a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_data;
    end
  end
  assign prdata = prdata_r;

  // Control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '{flag_rst: CFG_RST[CFG_FLAG_RST_BIT], trans_sel: CFG_RST[CFG_TRANS_BIT],
                 edge_sel: CFG_RST[CFG_EDGE_BIT], mode: CFG_RST[CFG_MODE_LSB +: 2]};
      ign_r <= IGN_RST;
      skew_r <= '{neg: SKEW_RST, pos: SKEW_RST};
      tsd_r <= TSD_RST; // RL10
      irq_mask_r <= IRQ_RST;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CFG: begin
          cfg_r.flag_rst <= pwdata[CFG_FLAG_RST_BIT];
          cfg_r.trans_sel <= pwdata[CFG_TRANS_BIT];
          cfg_r.edge_sel <= pwdata[CFG_EDGE_BIT];
          cfg_r.mode <= pwdata[CFG_MODE_LSB +: 2];
        end
        ADDR_IGN: ign_r <= pwdata[IGN_LSB +: 4];
        ADDR_SKEW: begin
          skew_r.neg <= pwdata[SKEW_NEG_LSB +: 2];
          skew_r.pos <= pwdata[SKEW_POS_LSB +: 2];
        end
        ADDR_TSD: tsd_r <= pwdata[TSD_LSB +: 7];
        ADDR_IRQ_MASK: irq_mask_r <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transition detect
  // ----------------------------------------------------------------
  // Polarity changed while enabled may give one spurious pulse;
  // software disables capture first, so no guard is spent.
  srcap_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sysref_in(sysref_in),
    .edge_sel(cfg_r.edge_sel),
    .trans_sel(cfg_r.trans_sel), // RL3
    .valid_pulse(valid_pulse)
  );

  // ----------------------------------------------------------------
  // Capture mode and N-shot sequence
  // ----------------------------------------------------------------
  // N-shot state: armed on entry to the mode, done after one action.
  always_comb begin
    ns_nxt = ns_r;
    case (ns_r)
      NS_IDLE: if (cfg_r.mode == MODE_NSHOT) ns_nxt = NS_ARMED;
      NS_ARMED: begin
        if (cfg_r.mode != MODE_NSHOT) begin
          ns_nxt = NS_IDLE;
        end else if (valid_pulse && skip_r == 4'h0) begin
          ns_nxt = NS_DONE;
        end
      end
      NS_DONE: if (cfg_r.mode == MODE_OFF) ns_nxt = NS_IDLE; // RL13
      default: ns_nxt = NS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ns_r <= NS_IDLE;
    end else begin
      ns_r <= ns_nxt;
    end
  end

  // Skip count loads while idle and counts down when armed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_r <= IGN_RST;
    end else if (ns_r == NS_IDLE) begin
      skip_r <= ign_r;
    end else if (ns_r == NS_ARMED && valid_pulse && skip_r != 4'h0) begin
      skip_r <= skip_r - 4'h1; // RL6
    end
  end

  // Mode gating of valid transitions.
  always_comb begin
    case (cfg_r.mode) // RL5
      MODE_CONT: capture = valid_pulse;
      MODE_NSHOT: capture = valid_pulse && ns_r == NS_ARMED && skip_r == 4'h0; // RL6
      default: capture = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Skew window check against the local frame phase
  // ----------------------------------------------------------------
  // SYSREF is expected at phase zero; late distance is the phase,
  // early distance the rest of the frame.
  assign late_dist = {1'b0, ph_r};
  assign early_dist = (PH_W + 1)'(FRAME_LEN) - {1'b0, ph_r};
  assign misaligned = capture && ph_r != '0; // RL9
  always_comb begin
    setup_err = 1'b0;
    hold_err = 1'b0;
    if (misaligned && late_dist > {{(PH_W - 1){1'b0}}, skew_r.pos} // RL8
        && early_dist > {{(PH_W - 1){1'b0}}, skew_r.neg}) begin // RL7
      if (ph_r[PH_W-1]) begin
        setup_err = 1'b1;
      end else begin
        hold_err = 1'b1;
      end
    end
  end

  // Phase counter realigns only on a capture outside the windows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= '0;
    end else if (setup_err || hold_err) begin
      ph_r <= PH_W'(1);
    end else begin
      ph_r <= ph_r + PH_W'(1);
    end
  end
  assign frame_phase = ph_r;

  // Sticky error flags, held clear during flag reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_flag_r <= 1'b0;
      hold_flag_r <= 1'b0;
    end else if (cfg_r.flag_rst) begin
      setup_flag_r <= 1'b0; // RL1
      hold_flag_r <= 1'b0; // RL1
    end else begin
      setup_flag_r <= setup_flag_r | setup_err;
      hold_flag_r <= hold_flag_r | hold_err;
    end
  end

  // Capture counter; stable to read only while capture is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= COUNT_RST;
    end else if (cfg_r.flag_rst) begin
      count_r <= COUNT_RST; // RL11
    end else if (capture) begin
      count_r <= count_r + 8'h01; // RL11
    end
  end

  // ----------------------------------------------------------------
  // Capture pulse and timestamp
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capt_r <= 1'b0;
    end else begin
      capt_r <= capture;
    end
  end
  assign capture_pulse = capt_r;

  // Timestamp delay counts from the capture cycle.
  srcap_delay_line #(
    .DEPTH(DLY_DEPTH)
  ) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .pulse_in(capture),
    .tap(TAP_W'(tsd_r)), // RL10
    .pulse_out(stamp_pulse)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_evt = {hold_err, setup_err, capture};

  // Write one to clear; a same-cycle event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= IRQ_RST;
    end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

endmodule

// ### src/srcap_pkg.sv
// Package with register map, field layout and shared types of the SYSREF capture block.
package srcap_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IDX_CFG = 12'h120;
  localparam logic [ADDR_W-1:0] IDX_IGN = 12'h121;
  localparam logic [ADDR_W-1:0] IDX_SKEW = 12'h122;
  localparam logic [ADDR_W-1:0] IDX_TSD = 12'h123;
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 12'h128;
  localparam logic [ADDR_W-1:0] IDX_COUNT = 12'h12A;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h130;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h131;
  localparam logic [ADDR_W-1:0] ADDR_CFG = IDX_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_IGN = IDX_IGN << 2;
  localparam logic [ADDR_W-1:0] ADDR_SKEW = IDX_SKEW << 2;
  localparam logic [ADDR_W-1:0] ADDR_TSD = IDX_TSD << 2;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = IDX_FLAGS << 2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = IDX_COUNT << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = IDX_IRQ_STAT << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_FLAG_RST_BIT = 6;
  localparam int CFG_TRANS_BIT = 4;
  localparam int CFG_EDGE_BIT = 3;
  localparam int CFG_MODE_LSB = 1;
  localparam int IGN_LSB = 0;
  localparam int SKEW_NEG_LSB = 2;
  localparam int SKEW_POS_LSB = 0;
  localparam int TSD_LSB = 0;
  localparam int FLAG_SETUP_BIT = 0;
  localparam int FLAG_HOLD_BIT = 4;
  localparam int IRQ_CAPT_BIT = 0;
  localparam int IRQ_SETUP_BIT = 1;
  localparam int IRQ_HOLD_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] IGN_RST = 4'h0;
  localparam logic [1:0] SKEW_RST = 2'h0;
  localparam logic [6:0] TSD_RST = 7'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ----------------------------------------------------------------
  // Modes, states and carriers
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_NSHOT = 2'h2;
  localparam int FRAME_LEN_DEF = 16;
  localparam int DLY_DEPTH_DEF = 128;

  typedef enum logic [2:0] {
    NS_IDLE = 3'b001,
    NS_ARMED = 3'b010,
    NS_DONE = 3'b100
  } srcap_nshot_t;

  typedef struct packed {
    logic flag_rst;
    logic trans_sel;
    logic edge_sel;
    logic [1:0] mode;
  } srcap_cfg_t;

  typedef struct packed {
    logic [1:0] neg;
    logic [1:0] pos;
  } srcap_skew_t;

endpackage

// ### src/srcap_edge_detect.sv
// Samples SYSREF on the selected clock edge and flags valid transitions.
`timescale 1ns/1ps
module srcap_edge_detect
  import srcap_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Reference input and selection.
  input wire logic sysref_in,
  input wire logic edge_sel,
  input wire logic trans_sel,
  // One-cycle pulse per valid transition.
  output logic valid_pulse
);

  logic rise_smp_r;
  logic fall_smp_r;
  logic fall_ret_r;
  logic prev_r;
  logic pulse_r;
  logic cur;

  // ----------------------------------------------------------------
  // Edge samplers
  // ----------------------------------------------------------------
  // Rising edge sampler.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_smp_r <= 1'b0;
    end else begin
      rise_smp_r <= sysref_in;
    end
  end

  // Falling edge sampler, retimed below to one clock edge.
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_smp_r <= 1'b0;
    end else begin
      fall_smp_r <= sysref_in;
    end
  end

  // Retime the falling sample onto the rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_ret_r <= 1'b0;
    end else begin
      fall_ret_r <= fall_smp_r;
    end
  end

  assign cur = edge_sel ? fall_ret_r : rise_smp_r; // RL4

  // ----------------------------------------------------------------
  // Transition detect
  // ----------------------------------------------------------------
  // Polarity decides whether low-to-high or high-to-low counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      prev_r <= cur;
      pulse_r <= trans_sel ? (prev_r & ~cur) : (~prev_r & cur); // RL2
    end
  end

  assign valid_pulse = pulse_r;

endmodule

// ### src/srcap_delay_line.sv
// Programmable pulse delay line used for the timestamp.
`timescale 1ns/1ps
module srcap_delay_line
  import srcap_pkg::*;
#(
  parameter int DEPTH = DLY_DEPTH_DEF
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pulse in and selected tap.
  input wire logic pulse_in,
  input wire logic [$clog2(DEPTH)-1:0] tap,
  // Delayed pulse, registered.
  output logic pulse_out
);

  logic [DEPTH-1:0] sh_r;
  logic out_r;

  if (DEPTH < 2) begin : g_chk
    $error("srcap_delay_line needs DEPTH of at least 2");
  end

  // Shift register; tap 0 is the input itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[DEPTH-2:0], pulse_in};
    end
  end

  // Registered so the tap mux never glitches outward.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
    end else if (tap == '0) begin
      out_r <= pulse_in;
    end else begin
      out_r <= sh_r[tap-1'b1];
    end
  end

  assign pulse_out = out_r;

endmodule

// ### sim/srcap_ctrl_props.sv
// Concurrent checks on the ports of the SYSREF capture control block.
`timescale 1ns/1ps
module srcap_ctrl_props
  import srcap_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_LEN_DEF,
  parameter int DLY_DEPTH = DLY_DEPTH_DEF
)
(
  // APB side.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Capture side.
  input wire logic sysref_in,
  input wire logic capture_pulse,
  input wire logic stamp_pulse,
  input wire logic [$clog2(FRAME_LEN)-1:0] frame_phase,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Shadows of what software wrote
  // ------------------------------------------------------------
  logic wr_now;
  logic mapped;
  logic cont;
  logic on;
  srcap_cfg_t cfg_r;
  logic [6:0] tsd_r;
  logic [7:0] age_r;
  logic [IRQ_W-1:0] mask_r;
  logic done_r;
  logic [127:0] hist_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes and the register map.
  assign wr_now = psel && penable && pwrite && pready;
  assign mapped = paddr inside {ADDR_CFG, ADDR_IGN, ADDR_SKEW, ADDR_TSD, ADDR_FLAGS,
    ADDR_COUNT, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
  assign cont = cfg_r.mode == MODE_CONT;
  assign on = cfg_r.mode inside {MODE_CONT, MODE_NSHOT};
  // Age since the delay was written, so pulses from an old tap are skipped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '0;
      tsd_r <= '0;
      age_r <= '0;
      mask_r <= '0;
      done_r <= 1'b0;
      hist_r <= '0;
    end else begin
      hist_r <= {hist_r[126:0], capture_pulse};
      age_r <= (wr_now && paddr == ADDR_TSD) ? 8'h00 : age_r + {7'h0, age_r != 8'hFF};
      if (wr_now && paddr == ADDR_CFG) cfg_r <= {pwdata[6], pwdata[4:1]};
      if (wr_now && paddr == ADDR_TSD) tsd_r <= pwdata[6:0];
      if (wr_now && paddr == ADDR_IRQ_MASK) mask_r <= pwdata[IRQ_W-1:0];
      if (wr_now && paddr == ADDR_CFG) done_r <= 1'b0;
      else if (capture_pulse && cfg_r.mode == MODE_NSHOT) done_r <= 1'b1;
    end
  end
  apb_resp_a: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("APB response wrong");
  rise_cap_a: assert property ($rose(sysref_in) && cont && !cfg_r.trans_sel |-> ##[2:4] capture_pulse)
    else $error("rising reference not captured");
  fall_cap_a: assert property ($fell(sysref_in) && cont && cfg_r.trans_sel |-> ##[2:4] capture_pulse)
    else $error("falling reference not captured");
  wrong_pol_a: assert property ((cfg_r.trans_sel ? $rose(sysref_in) : $fell(sysref_in)) && cont |-> ##1 !capture_pulse [*3])
    else $error("wrong polarity captured");
  mode_gate_a: assert property (capture_pulse |-> $past(on, 2) || $past(on, 3))
    else $error("capture while disabled");
  nshot_once_a: assert property (done_r |-> !capture_pulse)
    else $error("second capture in one shot");
  stamp_dly_a: assert property (age_r > 8'd135 |-> stamp_pulse == (tsd_r == 7'd0 ? capture_pulse : hist_r[tsd_r - 7'd1]))
    else $error("timestamp delay wrong");
  irq_mask_a: assert property (mask_r == '0 |-> !irq)
    else $error("masked interrupt seen");
  irq_cap_a: assert property (capture_pulse && mask_r[IRQ_CAPT_BIT] |-> ##[0:1] irq)
    else $error("capture interrupt missing");
  flags_hold_a: assert property (psel && penable && !pwrite && paddr == ADDR_FLAGS && cfg_r.flag_rst |-> prdata == 32'h0)
    else $error("flags not held clear");
  cover property (capture_pulse && cfg_r.mode == MODE_NSHOT);
  cover property (stamp_pulse && tsd_r == 7'd127);
  cover property (psel && penable && pslverr);
endmodule
bind srcap_ctrl srcap_ctrl_props #(.FRAME_LEN(FRAME_LEN), .DLY_DEPTH(DLY_DEPTH)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sysref_in(sysref_in), .capture_pulse(capture_pulse), .stamp_pulse(stamp_pulse),
  .frame_phase(frame_phase), .irq(irq));

// ### sim/srcap_sysref_gen.sv
// Behavioural reference source standing in for the clock generator.
`timescale 1ns/1ps
module srcap_sysref_gen (
  // Converter clock in, reference out.
  input wire logic pclk,
  output logic sysref
);
  int cyc = 0;
  int last_rise = 0;
  // Edge count for exact pulse spacing.
  always @(posedge pclk) cyc <= cyc + 1;
  initial sysref = 1'b0;
  // Rise gap clocks after the last rise, hold six, fall, rest six.
  task automatic pulse(input int gap);
    do @(posedge pclk); while (cyc - last_rise < gap);
    sysref <= 1'b1;
    last_rise = cyc;
    repeat (6) @(posedge pclk);
    sysref <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the SYSREF capture control block.
`timescale 1ns/1ps
module testbench;
  import srcap_pkg::*;
  // ------------------------------------------------------------
  // Signals, models and helpers
  // ------------------------------------------------------------
  localparam int FL = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sysref_in;
  logic capture_pulse;
  logic stamp_pulse;
  logic [$clog2(FL)-1:0] frame_phase;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_cap = 0;
  int cap_cyc = 0;
  int stamp_cyc = 0;
  int exp_cnt = 0;
  // Xorshift state, seeded with 93340.
  logic [31:0] seed = 32'h0001_6C9C;
  logic [ADDR_W-1:0] ra [8] = '{ADDR_CFG, ADDR_IGN, ADDR_SKEW, ADDR_TSD, ADDR_FLAGS,
    ADDR_COUNT, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
  // Writable bits per register.
  logic [31:0] rw [8] = '{32'h0000_005E, 32'h0000_000F, 32'h0000_000F, 32'h0000_007F,
    32'h0, 32'h0, 32'h0, 32'h0000_0007};
  // Clock of 100 ns period.
  always #50 pclk = ~pclk;
  srcap_ctrl #(.FRAME_LEN(FL), .DLY_DEPTH(128)) srcap_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref_in(sysref_in), .capture_pulse(capture_pulse), .stamp_pulse(stamp_pulse),
    .frame_phase(frame_phase), .irq(irq));
  srcap_sysref_gen srcap_sysref_gen_i (.pclk(pclk), .sysref(sysref_in));
  // Note when capture and stamp pulses appear.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (capture_pulse === 1'b1) begin
      n_cap <= n_cap + 1;
      cap_cyc <= cyc;
    end
    if (stamp_pulse === 1'b1) stamp_cyc <= cyc;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] cfgv(input logic fr, input logic tr, input logic ed,
                                       input logic [1:0] md);
    return {25'h0, fr, 1'b0, tr, ed, md, 1'b0};
  endfunction
  // Expected setup and hold bits for a capture p clocks off frame.
  function automatic logic [31:0] skew_exp(input logic [31:0] w, input int p);
    if (p == 0 || p <= int'(w[1:0]) || FL - p <= int'(w[3:2])) return 32'h0;
    return (p >= FL / 2) ? 32'h1 : 32'h2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic sr(input int gap);
    srcap_sysref_gen_i.pulse(gap);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    logic [31:0] v;
    int k;
    int c0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], q);
      chk(q, 32'h0, "reset value");
      wr(ra[i], 32'hFFFF_FFFF);
      rd(ra[i], q);
      chk(q, rw[i], "access kind");
      wr(ra[i], 32'h0);
    end
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk(q, 32'h0, "unmapped data");
    chk(e, 1'b1, "unmapped error");
    $display("register test done");
    // All modes, polarities and clock edges.
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_CFG, cfgv(1'b0, i[2], i[3], MODE_OFF));
      wr(ADDR_CFG, cfgv(1'b0, i[2], i[3], i[1:0]));
      c0 = n_cap;
      sr(0);
      k = (i[1:0] == MODE_CONT || i[1:0] == MODE_NSHOT) ? 1 : 0;
      exp_cnt += k;
      chk(n_cap - c0, k, "mode capture");
    end
    $display("mode test done");
    // A aligns the frame; B lands p clocks off it.
    wr(ADDR_CFG, cfgv(1'b0, 1'b0, 1'b0, MODE_CONT));
    for (int s = 0; s < 3; s++) begin
      v = (s == 0) ? 32'h0 : (s == 1) ? 32'hF : (rnd() & 32'hF);
      for (int p = 0; p < FL; p++) begin
        wr(ADDR_SKEW, 32'h0);
        sr(0);
        wr(ADDR_SKEW, v);
        wr(ADDR_IRQ_STAT, 32'h7);
        sr(3 * FL + p);
        rd(ADDR_IRQ_STAT, q);
        chk(q[2:1], skew_exp(v, p), "skew flags");
        exp_cnt += 2;
      end
    end
    wr(ADDR_CFG, cfgv(1'b0, 1'b0, 1'b0, MODE_OFF));
    rd(ADDR_COUNT, q);
    chk(q, exp_cnt % 256, "capture count");
    wr(ADDR_CFG, cfgv(1'b1, 1'b0, 1'b0, MODE_OFF));
    rd(ADDR_FLAGS, q);
    chk(q, 32'h0, "flags held");
    rd(ADDR_COUNT, q);
    chk(q, 32'h0, "count cleared");
    wr(ADDR_CFG, 32'h0);
    $display("skew and flag test done");
    for (int t = 0; t < 4; t++) begin
      k = (t == 0) ? 0 : (t == 1) ? 1 : (t == 2) ? 15 : int'(rnd() & 32'hF);
      wr(ADDR_CFG, cfgv(1'b0, 1'b0, 1'b0, MODE_OFF));
      wr(ADDR_IGN, k);
      wr(ADDR_CFG, cfgv(1'b0, 1'b0, 1'b0, MODE_NSHOT));
      c0 = n_cap;
      repeat (k) sr(0);
      chk(n_cap - c0, 0, "skipped edges");
      sr(0);
      chk(n_cap - c0, 1, "shot taken");
      sr(0);
      chk(n_cap - c0, 1, "shot spent");
    end
    $display("one shot test done");
    wr(ADDR_CFG, cfgv(1'b0, 1'b0, 1'b0, MODE_CONT));
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h7);
    sr(0);
    chk(irq, 1'b1, "irq raised");
    rd(ADDR_IRQ_STAT, q);
    chk(q[0], 1'b1, "capture status");
    wr(ADDR_IRQ_STAT, 32'h1);
    @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    wr(ADDR_IRQ_MASK, 32'h0);
    sr(0);
    chk(irq, 1'b0, "irq masked");
    $display("interrupt test done");
    // Timestamp delay: both ends and one random value.
    for (int t = 0; t < 3; t++) begin
      k = (t == 0) ? 0 : (t == 1) ? 127 : int'(rnd() & 32'h7F);
      wr(ADDR_TSD, k);
      repeat (140) @(posedge pclk);
      sr(0);
      repeat (130) @(posedge pclk);
      chk(stamp_cyc - cap_cyc, k, "stamp delay");
    end
    $display("timestamp test done");
    report_and_stop();
  end
endmodule
